// File: hdl/pas_pkg.sv
// constants for the port A pin steering block: register map, fields, resets
// assumes an AXI4-Lite register bus with 32-bit data
package pas_pkg;
  localparam logic [3:0] OFS_PINS     = 4'h0;
  localparam logic [3:0] OFS_LATCH    = 4'h4;
  localparam logic [3:0] OFS_DIR      = 4'h8;
  localparam logic [3:0] OFS_ANALOG   = 4'hC;
  localparam logic [4:0] OFS_STEER    = 5'h10;
  localparam logic [4:0] OFS_PKG      = 5'h14;
  localparam int PORT_WIDTH = 8;
  localparam int ANALOG_BITS = 6;
  localparam logic [7:0] DIR_RESET    = 8'hFF;
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [5:0] ANALOG_RESET = 6'h3F;
  localparam logic [6:0] STEER_RESET  = 7'h00;
  localparam int SEL_CAP2 = 0;
  localparam int SEL_SS = 1;
  localparam int SEL_COMP2 = 2;
  localparam int SEL_SRINV = 3;
  localparam int SEL_PWM2B = 4;
  localparam int SEL_TIMER1_GATE = 5;
  localparam int SEL_CAP3 = 6;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    PAS_IDLE = 2'b01,
    PAS_RESP = 2'b10
  } pas_wstate_t;
endpackage

// File: hdl/pas_sync.sv
// two flip-flop synchroniser for the port A pin levels
// assumes pins are asynchronous to clock
`timescale 1ns/10ps
`default_nettype none
module pas_sync
  import pas_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [PORT_WIDTH-1:0] din,
  output logic      [PORT_WIDTH-1:0] dout
);
  logic [PORT_WIDTH-1:0] stage1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pas_pin_mux.sv
// per-pin output priority selection for port A
// assumes peripheral enables and data come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module pas_pin_mux
  import pas_pkg::*;
(
  input  wire logic [PORT_WIDTH-1:0] latch,
  input  wire logic [PORT_WIDTH-1:0] dir,
  input  wire logic                  pkg40,
  input  wire logic                  regCapOn0,
  input  wire logic                  regCapOn5,
  input  wire logic                  regCapOn6,
  input  wire logic [PORT_WIDTH-1:0] lcdEn,
  input  wire logic [PORT_WIDTH-1:0] lcdOut,
  input  wire logic                  lcdComEn2,
  input  wire logic                  lcdComOut2,
  input  wire logic                  lcdComEn3,
  input  wire logic                  lcdComOut3,
  input  wire logic                  srInvEn0,
  input  wire logic                  srInvEn5,
  input  wire logic                  srInvOut,
  input  wire logic                  srTrueEn,
  input  wire logic                  srTrueOut,
  input  wire logic                  comp2En0,
  input  wire logic                  comp2En5,
  input  wire logic                  comp2Out,
  input  wire logic                  comp1En,
  input  wire logic                  comp1Out,
  input  wire logic                  cap5En,
  input  wire logic                  cap5Out,
  input  wire logic                  dacEn,
  input  wire logic                  dac_output,
  input  wire logic                  oscOutEn,
  input  wire logic                  oscOut,
  input  wire logic                  clkOutEn,
  input  wire logic                  clock_output,
  input  wire logic                  oscInEn,
  output logic      [PORT_WIDTH-1:0] padOut,
  output logic      [PORT_WIDTH-1:0] padOe
);
  // peripherals own the driver; latch/direction apply only when none claims
  always_comb begin
    padOut = latch;
    padOe  = ~dir;
    // pin 0
    if (regCapOn0) begin
      padOut[0] = 1'b0;
      padOe[0] = 1'b0;
    end else if (lcdEn[0]) begin
      padOut[0] = lcdOut[0];
      padOe[0] = 1'b1;
    end else if (srInvEn0) begin
      padOut[0] = srInvOut;
      padOe[0] = 1'b1;
    end else if (comp2En0) begin
      padOut[0] = comp2Out;
      padOe[0] = 1'b1;
    end
    // pin 1
    if (lcdEn[1]) begin
      padOut[1] = lcdOut[1];
      padOe[1] = 1'b1;
    end
    // pin 2
    if (lcdComEn2) begin
      padOut[2] = lcdComOut2;
      padOe[2] = 1'b1;
    end else if (dacEn) begin
      padOut[2] = dac_output;
      padOe[2] = 1'b1;
    end
    // pin 3
    if (lcdComEn3 && !pkg40) begin
      padOut[3] = lcdComOut3;
      padOe[3] = 1'b1;
    end else if (lcdEn[3]) begin
      padOut[3] = lcdOut[3];
      padOe[3] = 1'b1;
    end
    // pin 4
    if (lcdEn[4]) begin
      padOut[4] = lcdOut[4];
      padOe[4] = 1'b1;
    end else if (srTrueEn) begin
      padOut[4] = srTrueOut;
      padOe[4] = 1'b1;
    end else if (comp1En) begin
      padOut[4] = comp1Out;
      padOe[4] = 1'b1;
    end else if (cap5En && !pkg40) begin
      padOut[4] = cap5Out;
      padOe[4] = 1'b1;
    end
    // pin 5
    if (regCapOn5) begin
      padOut[5] = 1'b0;
      padOe[5] = 1'b0;
    end else if (lcdEn[5]) begin
      padOut[5] = lcdOut[5];
      padOe[5] = 1'b1;
    end else if (srInvEn5) begin
      padOut[5] = srInvOut;
      padOe[5] = 1'b1;
    end else if (comp2En5) begin
      padOut[5] = comp2Out;
      padOe[5] = 1'b1;
    end
    // pin 6
    if (regCapOn6) begin
      padOut[6] = 1'b0;
      padOe[6] = 1'b0;
    end else if (oscOutEn) begin
      padOut[6] = oscOut;
      padOe[6] = 1'b1;
    end else if (clkOutEn) begin
      padOut[6] = clock_output;
      padOe[6] = 1'b1;
    end else if (lcdEn[6]) begin
      padOut[6] = lcdOut[6];
      padOe[6] = 1'b1;
    end
    // pin 7: the oscillator input takes the pin, driver off
    if (oscInEn) begin
      padOut[7] = 1'b0;
      padOe[7] = 1'b0;
    end else if (lcdEn[7]) begin
      padOut[7] = lcdOut[7];
      padOe[7] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/port_a_pin_steering.sv
// port A GPIO with alternate-function steering, AXI4-Lite register slave
// assumes pads outside resolve padOut/padOe; peripherals share this clock
// What this block does
// - steering never changes any direction register
// - overrides follow the selected pin only
// - bit 6 moves capture three pin
// - bit 5 moves timer1 gate input
// - bit 4 moves PWM2 B output
// - bit 3 moves SR inverted output
// - bit 2 moves comparator two output
// - bit 1 moves slave select input
// - bit 0 moves capture two pin
// - bit 7 reads zero; reset clears steering
// - eight bidirectional bits, direction, latch, pin
// - direction one is input, zero drives latch
// - data read gives pins, write sets latch
// - port writes are read-modify-write
// - direction controls drivers on analog pins
// - analog pins read zero digitally
// - analog select leaves digital output alone
// - analog select resets to analog
// - highest enabled source owns the pin
// - analog mode still allows digital output drivers
// - priorities for pins zero, four, five
// - priorities for pins one, two, three, six, seven
`timescale 1ns/10ps
`default_nettype none
module port_a_pin_steering
  import pas_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [4:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [4:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [PORT_WIDTH-1:0] padIn,
  output logic      [PORT_WIDTH-1:0] padOut,
  output logic      [PORT_WIDTH-1:0] padOe,
  input  wire logic                  pkg40,
  input  wire logic                  regCapOn0,
  input  wire logic                  regCapOn5,
  input  wire logic                  regCapOn6,
  input  wire logic [PORT_WIDTH-1:0] lcdEn,
  input  wire logic [PORT_WIDTH-1:0] lcdOut,
  input  wire logic                  lcdComEn2,
  input  wire logic                  lcdComOut2,
  input  wire logic                  lcdComEn3,
  input  wire logic                  lcdComOut3,
  input  wire logic                  srInvEn,
  input  wire logic                  srInvOut,
  input  wire logic                  srTrueEn,
  input  wire logic                  srTrueOut,
  input  wire logic                  comp2En,
  input  wire logic                  comp2Out,
  input  wire logic                  comp1En,
  input  wire logic                  comp1Out,
  input  wire logic                  cap5En,
  input  wire logic                  cap5Out,
  input  wire logic                  dacEn,
  input  wire logic                  dac_output,
  input  wire logic                  oscOutEn,
  input  wire logic                  oscOut,
  input  wire logic                  clkOutEn,
  input  wire logic                  clock_output,
  input  wire logic                  oscInEn,
  output logic                       ssPinSel0,
  output logic                       comp2PinSel0,
  output logic                       srInvPinSel0,
  output logic                       timer1GatePinSel,
  output logic                       pwm2bPinSel,
  output logic                       cap2PinSel,
  output logic                       cap3PinSel,
  output logic                       slaveSelectIn
);
  logic [PORT_WIDTH-1:0]  portALatch;
  logic [PORT_WIDTH-1:0]  portADir;
  logic [ANALOG_BITS-1:0] portAAnalog;
  logic [6:0]             altPinSteering;
  logic [PORT_WIDTH-1:0]  pinSync;
  logic [PORT_WIDTH-1:0]  pinDigital;
  logic [PORT_WIDTH-1:0]  analogMask;
  pas_wstate_t            wState;
  logic                   awHeld;
  logic                   wHeld;
  logic [4:0]             awAddr;
  logic [31:0]            wData;
  logic                   wStrb0;
  logic                   wFire;

  pas_sync u_sync (
    .clock (clock),
    .rst   (rst),
    .din   (padIn),
    .dout  (pinSync)
  );

  // pins 6 and 7 have no analog select; their mask bits stay zero
  assign analogMask = {2'b00, portAAnalog};
  assign pinDigital = pinSync & ~analogMask;

  function automatic logic [31:0] readWord(input logic [4:0] a);
    begin
      case (a)
        {1'b0, OFS_PINS}:   readWord = {24'h000000, pinDigital};
        {1'b0, OFS_LATCH}:  readWord = {24'h000000, portALatch};
        {1'b0, OFS_DIR}:    readWord = {24'h000000, portADir};
        {1'b0, OFS_ANALOG}: readWord = {26'h0000000, portAAnalog};
        OFS_STEER:          readWord = {25'h0000000, altPinSteering};
        default:            readWord = 32'h00000000;
      endcase
    end
  endfunction

  function automatic logic mapped(input logic [4:0] a);
    begin
      mapped = (a[1:0] == 2'b00) && (a <= OFS_STEER);
    end
  endfunction

  // write channels: address and data accepted in either order
  assign s_axi_awready = (wState == PAS_IDLE) && !awHeld;
  assign s_axi_wready  = (wState == PAS_IDLE) && !wHeld;
  assign wFire = (wState == PAS_IDLE) && awHeld && wHeld;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= 5'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (wFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wHeld  <= 1'b0;
      wData  <= 32'h00000000;
      wStrb0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld  <= 1'b1;
      wData  <= s_axi_wdata;
      wStrb0 <= s_axi_wstrb[0];
    end else if (wFire) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wState       <= PAS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      case (wState)
        PAS_IDLE: begin
          if (wFire) begin
            wState       <= PAS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        PAS_RESP: begin
          if (s_axi_bready) begin
            wState       <= PAS_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wState       <= PAS_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // a write to either the pin or latch address lands in the latch; the
  // bus carries the full modified byte, so the stored value is the result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portALatch <= LATCH_RESET;
    end else if (wFire && wStrb0 &&
                 (awAddr == {1'b0, OFS_PINS} || awAddr == {1'b0, OFS_LATCH})) begin
      portALatch <= wData[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portADir <= DIR_RESET;
    end else if (wFire && wStrb0 && awAddr == {1'b0, OFS_DIR}) begin
      portADir <= wData[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portAAnalog <= ANALOG_RESET;
    end else if (wFire && wStrb0 && awAddr == {1'b0, OFS_ANALOG}) begin
      portAAnalog <= wData[ANALOG_BITS-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      altPinSteering <= STEER_RESET;
    end else if (wFire && wStrb0 && awAddr == OFS_STEER) begin
      altPinSteering <= wData[6:0];
    end
  end

  // read channel: one outstanding read, data registered
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= readWord(s_axi_araddr);
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // steering decode: peripherals see which candidate pin is live
  assign cap3PinSel       = altPinSteering[SEL_CAP3];
  assign timer1GatePinSel = altPinSteering[SEL_TIMER1_GATE];
  assign pwm2bPinSel      = altPinSteering[SEL_PWM2B];
  assign srInvPinSel0     = altPinSteering[SEL_SRINV];
  assign comp2PinSel0     = altPinSteering[SEL_COMP2];
  assign ssPinSel0        = altPinSteering[SEL_SS];
  assign cap2PinSel       = altPinSteering[SEL_CAP2];
  // slave select read through the analog mask of the chosen pin
  assign slaveSelectIn = ssPinSel0 ? pinDigital[0] : pinDigital[5];

  pas_pin_mux u_mux (
    .latch      (portALatch),
    .dir        (portADir),
    .pkg40      (pkg40),
    .regCapOn0  (regCapOn0),
    .regCapOn5  (regCapOn5),
    .regCapOn6  (regCapOn6),
    .lcdEn      (lcdEn),
    .lcdOut     (lcdOut),
    .lcdComEn2  (lcdComEn2),
    .lcdComOut2 (lcdComOut2),
    .lcdComEn3  (lcdComEn3),
    .lcdComOut3 (lcdComOut3),
    .srInvEn0   (srInvEn && srInvPinSel0),
    .srInvEn5   (srInvEn && !srInvPinSel0),
    .srInvOut   (srInvOut),
    .srTrueEn   (srTrueEn),
    .srTrueOut  (srTrueOut),
    .comp2En0   (comp2En && comp2PinSel0),
    .comp2En5   (comp2En && !comp2PinSel0),
    .comp2Out   (comp2Out),
    .comp1En    (comp1En),
    .comp1Out   (comp1Out),
    .cap5En     (cap5En),
    .cap5Out    (cap5Out),
    .dacEn      (dacEn),
    .dac_output     (dac_output),
    .oscOutEn   (oscOutEn),
    .oscOut     (oscOut),
    .clkOutEn   (clkOutEn),
    .clock_output     (clock_output),
    .oscInEn    (oscInEn),
    .padOut     (padOut),
    .padOe      (padOe)
  );

  a_steer_reset: assert property (@(posedge clock)
    $rose(rst) |=> altPinSteering == 7'h00)
    else $error("steering not cleared by reset");
  a_dir_steady: assert property (@(posedge clock) disable iff (rst)
    (wFire && awAddr == OFS_STEER) |=> $stable(portADir))
    else $error("direction changed by steering write");
  a_analog_zero: assert property (@(posedge clock) disable iff (rst)
    portAAnalog[0] |-> !pinDigital[0])
    else $error("analog pin read non-zero");
  a_latch_drive: assert property (@(posedge clock) disable iff (rst)
    (!portADir[1] && !lcdEn[1]) |-> (padOe[1] && padOut[1] == portALatch[1]))
    else $error("latch not driven");
  a_input_off: assert property (@(posedge clock) disable iff (rst)
    (portADir[1] && !lcdEn[1]) |-> !padOe[1])
    else $error("input pin driven");
  a_comp_route: assert property (@(posedge clock) disable iff (rst)
    (comp2En && !comp2PinSel0 && !regCapOn5 && !lcdEn[5] && !srInvEn) |->
    (padOe[5] && padOut[5] == comp2Out))
    else $error("comparator two not on pin five");
  a_desel_pin: assert property (@(posedge clock) disable iff (rst)
    (!comp2PinSel0 && !srInvPinSel0 && !regCapOn0 && !lcdEn[0]) |->
    (padOe[0] == !portADir[0]))
    else $error("deselected pin disturbed");
  sequence s_wr_taken;
    wFire;
  endsequence
  a_bresp_next: assert property (@(posedge clock) disable iff (rst)
    s_wr_taken |=> s_axi_bvalid)
    else $error("write response missing");
  a_latch_write: assert property (@(posedge clock) disable iff (rst)
    (wFire && wStrb0 && awAddr == {1'b0, OFS_PINS}) |=> portALatch == $past(wData[7:0]))
    else $error("port write missed latch");
  a_prio_pin4: assert property (@(posedge clock) disable iff (rst)
    (lcdEn[4] && srTrueEn) |-> padOut[4] == lcdOut[4])
    else $error("pin four priority wrong");
  // read data stands one cycle after the address is taken
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_rvalid_next: assert property (@(posedge clock) disable iff (rst)
    s_rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  a_cap_pin0: assert property (@(posedge clock) disable iff (rst)
    regCapOn0 |-> !padOe[0])
    else $error("pin zero driven under regulator capacitor");
  a_sr_route0: assert property (@(posedge clock) disable iff (rst)
    (srInvEn && srInvPinSel0 && !regCapOn0 && !lcdEn[0]) |->
    (padOe[0] && padOut[0] == srInvOut))
    else $error("inverted latch output not on pin zero");
  a_com_pin2: assert property (@(posedge clock) disable iff (rst)
    lcdComEn2 |-> (padOe[2] && padOut[2] == lcdComOut2))
    else $error("pin two common line lost priority");
  a_osc_pin6: assert property (@(posedge clock) disable iff (rst)
    (!regCapOn6 && oscOutEn) |-> (padOe[6] && padOut[6] == oscOut))
    else $error("oscillator output lost pin six");
  a_cap_pin6: assert property (@(posedge clock) disable iff (rst)
    regCapOn6 |-> !padOe[6])
    else $error("pin six driven under regulator capacitor");
  a_osc_pin7: assert property (@(posedge clock) disable iff (rst)
    oscInEn |-> !padOe[7])
    else $error("pin seven driven while oscillator input");
  a_ss_pin0: assert property (@(posedge clock) disable iff (rst)
    (ssPinSel0 && !portAAnalog[0]) |-> slaveSelectIn == pinSync[0])
    else $error("slave select not from pin zero");
endmodule
`default_nettype wire

// File: testbench/pas_far_side.sv
// far-side model of port A: each pad resolved between the block and an outside source
// assumes padOe high means the block drives the pad
`timescale 1ns/10ps
`default_nettype none
module pas_far_side
  import pas_pkg::*;
(
  input  wire logic [PORT_WIDTH-1:0] padOut,
  input  wire logic [PORT_WIDTH-1:0] padOe,
  input  wire logic [PORT_WIDTH-1:0] extLevel,
  output logic      [PORT_WIDTH-1:0] padIn
);
  // a driven pad reads back the block, a released one follows the outside source
  assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule
`default_nettype wire

// File: testbench/port_a_pin_steering_test.sv
// self-checking bench for port A steering: register traffic and pad checks
// assumes pas_far_side resolves the pads; stimulus moves just after rising edges
`timescale 1ns/10ps
`default_nettype none
module port_a_pin_steering_test;
  import pas_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ssIn;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  padIn, padOut, padOe, ext = 8'h00, lcdEn = 8'h00, lcdOut = 8'h00;
  logic [23:0] per = 24'h0;
  logic        pkg40 = 1'b0;
  wire  [6:0]  sel;
  int          fails = 0, n_compared = 0;

  always #4 clock = ~clock;

  port_a_pin_steering dut (
    .clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .pkg40(pkg40), .regCapOn0(per[0]),
    .regCapOn5(per[1]), .regCapOn6(per[2]), .lcdEn(lcdEn), .lcdOut(lcdOut),
    .lcdComEn2(per[3]), .lcdComOut2(per[4]), .lcdComEn3(per[5]), .lcdComOut3(per[6]),
    .srInvEn(per[7]), .srInvOut(per[8]), .srTrueEn(per[9]), .srTrueOut(per[10]),
    .comp2En(per[11]), .comp2Out(per[12]), .comp1En(per[13]), .comp1Out(per[14]),
    .cap5En(per[15]), .cap5Out(per[16]), .dacEn(per[17]), .dac_output(per[18]),
    .oscOutEn(per[19]), .oscOut(per[20]), .clkOutEn(per[21]), .clock_output(per[22]),
    .oscInEn(per[23]), .ssPinSel0(sel[1]), .comp2PinSel0(sel[2]), .srInvPinSel0(sel[3]),
    .timer1GatePinSel(sel[5]), .pwm2bPinSel(sel[4]), .cap2PinSel(sel[0]),
    .cap3PinSel(sel[6]), .slaveSelectIn(ssIn));

  pas_far_side far (.padOut(padOut), .padOe(padOe), .extLevel(ext), .padIn(padIn));

  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // starts one edge late so no handshake signal is assigned twice in a time step
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    resp = bresp;
    if (i == 50) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic rdr(input logic [4:0] a);
    int i;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
    if (i == 50) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic t_reset;
    rdr(5'h08);
    cmp(rd, 32'hFF);
    rdr(5'h0C);
    cmp(rd, 32'h3F);
    rdr(5'h10);
    cmp(rd, 32'h00);
    rdr(5'h04);
    cmp(rd, {24'h0, LATCH_RESET});
    cmp({24'h0, padOe}, 32'h00);
  endtask

  task automatic t_steer;
    for (int b = 0; b < 7; b++) begin
      wr(5'h10, 32'h1 << b);
      @(negedge clock);
      cmp({25'h0, sel}, 32'h1 << b);
    end
    wr(5'h10, 32'hFF);
    rdr(5'h10);
    cmp(rd, 32'h7F);
    rdr(5'h08);
    cmp(rd, 32'hFF);
  endtask

  task automatic t_pins;
    @(posedge clock);
    ext <= 8'h5A;
    wr(5'h04, 32'hA5);
    wr(5'h08, 32'h0F);
    @(negedge clock);
    cmp({24'h0, padOe}, 32'hF0);
    cmp({24'h0, padOut & 8'hF0}, 32'hA0);
    rdr(5'h00);
    cmp(rd, 32'h80);
    wr(5'h0C, 32'h00);
    rdr(5'h00);
    cmp(rd, 32'hAA);
    wr(5'h00, 32'h3C);
    rdr(5'h04);
    cmp(rd, 32'h3C);
    cmp({24'h0, padOut & 8'hF0}, 32'h30);
  endtask

  task automatic t_prio;
    wr(5'h10, 32'h00);
    wr(5'h08, 32'h00);
    wr(5'h04, 32'hFF);
    @(posedge clock);
    per[12:11] <= 2'b01;
    @(negedge clock);
    cmp({24'h0, padOut}, 32'hDF);
    @(posedge clock);
    per[8:7] <= 2'b11;
    @(negedge clock);
    cmp({24'h0, padOut}, 32'hFF);
    @(posedge clock);
    lcdEn <= 8'h20;
    @(negedge clock);
    cmp({24'h0, padOut}, 32'hDF);
    @(posedge clock);
    per[1] <= 1'b1;
    @(negedge clock);
    cmp({24'h0, padOe}, 32'hDF);
    @(posedge clock);
    per[8] <= 1'b0;
    per[1] <= 1'b0;
    lcdEn <= 8'h00;
    wr(5'h10, 32'h0C);
    @(negedge clock);
    cmp({24'h0, padOut}, 32'hFE);
    wr(5'h10, 32'h04);
    @(negedge clock);
    cmp({24'h0, padOut}, 32'hDE);
    @(posedge clock);
    per[18:15] <= 4'h5;
    @(negedge clock);
    cmp({24'h0, padOut}, 32'hCA);
    @(posedge clock);
    per[4:3] <= 2'b11;
    pkg40 <= 1'b1;
    @(negedge clock);
    cmp({24'h0, padOut}, 32'hDE);
    @(posedge clock);
    per[23:19] <= 5'h1D;
    per[0] <= 1'b1;
    @(negedge clock);
    cmp({24'h0, padOut}, 32'h1E);
    cmp({24'h0, padOe}, 32'h7E);
    @(posedge clock);
    per[19] <= 1'b0;
    @(negedge clock);
    cmp({24'h0, padOut}, 32'h5E);
    @(posedge clock);
    per[2] <= 1'b1;
    @(negedge clock);
    cmp({24'h0, padOe}, 32'h3E);
  endtask

  // the pads pass a two-stage synchroniser, so a few edges pass before sampling
  task automatic t_ss;
    @(posedge clock);
    per <= 24'h0;
    ext <= 8'h20;
    wr(5'h08, 32'hFF);
    wr(5'h10, 32'h00);
    repeat (4) @(posedge clock);
    @(negedge clock);
    cmp({31'h0, ssIn}, 32'h1);
    wr(5'h10, 32'h02);
    @(negedge clock);
    cmp({31'h0, ssIn}, 32'h0);
    @(posedge clock);
    ext <= 8'h01;
    repeat (4) @(posedge clock);
    @(negedge clock);
    cmp({31'h0, ssIn}, 32'h1);
    wr(5'h0C, 32'h01);
    repeat (4) @(posedge clock);
    @(negedge clock);
    cmp({31'h0, ssIn}, 32'h0);
  endtask

  task automatic t_bus;
    wr(5'h14, 32'h1);
    cmp({30'h0, resp}, 32'h2);
    rdr(5'h14);
    cmp({30'h0, resp}, 32'h2);
    cmp(rd, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_steer();
    t_pins();
    t_prio();
    t_ss();
    t_bus();
    wr(5'h10, 32'h55);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rdr(5'h10);
    cmp(rd, 32'h00);
    complete_run();
  end
endmodule
`default_nettype wire
